// *** verilog/bst_pkg.sv ***
package bst_pkg;

  localparam int BST_IR_LEN = 10;
  localparam int BST_ID_LEN = 32;
  localparam int BST_UC_USER_LEN = 7;
  localparam int BST_UC_FIXED_LEN = 25;
  localparam int BST_BSR_LEN = 1050;
  localparam int BST_CFG_W = 8;
  localparam int BST_CFG_CNT_W = 3;

  // instruction codes; bypass is all ones and extest all zeros
  localparam logic [9:0] BST_OP_EXTEST = 10'h000;
  localparam logic [9:0] BST_OP_SAMPLE = 10'h005;
  localparam logic [9:0] BST_OP_IDCODE = 10'h006;
  localparam logic [9:0] BST_OP_USERCODE = 10'h007;
  localparam logic [9:0] BST_OP_CFG_LOAD = 10'h002;
  localparam logic [9:0] BST_OP_CFG_DONE = 10'h003;
  localparam logic [9:0] BST_OP_BYPASS = 10'h3ff;

  // value captured into the instruction register, low bits 01
  localparam logic [9:0] BST_IR_CAPTURE = 10'h001;
  localparam logic [9:0] BST_IR_RESET = BST_OP_IDCODE;

  // identity fields; values are arbitrary
  localparam logic [3:0] BST_ID_VERSION = 4'h3;
  localparam logic [15:0] BST_ID_PART = 16'h5a5a;
  localparam logic [10:0] BST_ID_MAKER = 11'h2a5;
  localparam logic BST_ID_LSB = 1'b1;
  // device-fixed part of the user signature; value is arbitrary
  localparam logic [24:0] BST_UC_FIXED = 25'h0c0ffee;

  typedef struct packed {
    logic [3:0] version;
    logic [15:0] part;
    logic [10:0] maker;
    logic lsb;
  } bst_idcode_t;

  typedef struct packed {
    logic [24:0] fixed;
    logic [6:0] user;
  } bst_usercode_t;

  typedef struct packed {
    logic busy;
    logic [7:0] data;
  } bst_cfg_t;

  typedef enum logic [3:0] {
    BST_EXIT2_DR = 4'b0000,
    BST_EXIT1_DR = 4'b0001,
    BST_SHIFT_DR = 4'b0010,
    BST_PAUSE_DR = 4'b0011,
    BST_SEL_IR = 4'b0100,
    BST_UPD_DR = 4'b0101,
    BST_CAP_DR = 4'b0110,
    BST_SEL_DR = 4'b0111,
    BST_EXIT2_IR = 4'b1000,
    BST_EXIT1_IR = 4'b1001,
    BST_SHIFT_IR = 4'b1010,
    BST_PAUSE_IR = 4'b1011,
    BST_IDLE = 4'b1100,
    BST_UPD_IR = 4'b1101,
    BST_CAP_IR = 4'b1110,
    BST_RESET = 4'b1111
  } bst_state_t;

endpackage

// *** verilog/bst_sync.sv ***
`timescale 1ns/1ps
module bst_sync
  import bst_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic rst,
  // raw and filtered levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  initial begin
    if (WIDTH < 1) begin
      $error("bst_sync width must be at least one");
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change is taken only once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule

// *** verilog/bst_xfer.sv ***
`timescale 1ns/1ps
module bst_xfer
  import bst_pkg::*;
(
  // link side
  input wire logic tck,
  input wire logic tck_rst,
  input wire logic byte_stb,
  input wire bst_cfg_t cfg_in,
  // system side
  input wire logic clk,
  input wire logic sys_rst,
  output bst_cfg_t cfg_out,
  output logic cfg_valid
);

  // held word is stable for eight link clocks, far longer than the
  // three system clocks the toggle needs, so no return handshake
  logic tog_reg;
  logic [7:0] hold_reg;
  logic busy_reg;
  logic t1_reg;
  logic t2_reg;
  logic t3_reg;
  logic b1_reg;
  logic b2_reg;

  always_ff @(posedge tck) begin
    if (tck_rst) begin
      tog_reg <= 1'b0;
      hold_reg <= 8'h00;
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= cfg_in.busy;
      if (byte_stb) begin
        tog_reg <= ~tog_reg;
        hold_reg <= cfg_in.data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t1_reg <= 1'b0;
      t2_reg <= 1'b0;
      t3_reg <= 1'b0;
      b1_reg <= 1'b0;
      b2_reg <= 1'b0;
    end else begin
      t1_reg <= tog_reg;
      t2_reg <= t1_reg;
      t3_reg <= t2_reg;
      b1_reg <= busy_reg;
      b2_reg <= b1_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_out <= '0;
      cfg_valid <= 1'b0;
    end else begin
      cfg_out.busy <= b2_reg;
      cfg_valid <= t2_reg ^ t3_reg;
      if (t2_reg ^ t3_reg) begin
        cfg_out.data <= hold_reg;
      end
    end
  end

endmodule

// *** verilog/bst_tap.sv ***
`timescale 1ns/1ps
module bst_tap
  import bst_pkg::*;
#(
  parameter int BSR_LEN = BST_BSR_LEN
) (
  // system side
  input wire logic clk,
  input wire logic sys_rst,
  // test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_out,
  output logic tdo_oe_n,
  output logic tms_pullup_en,
  output logic tdi_pullup_en,
  // device pins and core
  input wire logic [BSR_LEN-1:0] pin_in,
  input wire logic [BSR_LEN-1:0] core_out,
  output logic [BSR_LEN-1:0] pin_out,
  input wire logic [BST_UC_USER_LEN-1:0] user_code,
  // configuration data toward the array
  output bst_cfg_t cfg_out,
  output logic cfg_valid,
  output logic cfg_done
);

  bst_state_t state_reg;
  bst_state_t state_next;
  logic tck_rst;
  logic [BST_IR_LEN-1:0] ir_shift_reg;
  logic [BST_IR_LEN-1:0] ir_reg;
  logic bypass_reg;
  logic [BST_ID_LEN-1:0] id_shift_reg;
  logic [BST_ID_LEN-1:0] uc_shift_reg;
  logic [BSR_LEN-1:0] bsr_shift_reg;
  logic [BSR_LEN-1:0] bsr_upd_reg;
  logic [BST_CFG_W-1:0] cfg_shift_reg;
  logic [BST_CFG_CNT_W-1:0] cfg_cnt_reg;
  logic cfg_stb;
  logic cfg_busy_reg;
  logic cfg_done_reg;
  logic cfg_done_s1_reg;
  logic cfg_done_s2_reg;
  logic [BSR_LEN-1:0] pin_sync;
  logic [BST_UC_USER_LEN-1:0] user_sync;
  logic sel_bypass;
  logic sel_id;
  logic sel_uc;
  logic sel_bsr;
  logic sel_cfg;
  logic tdo_next;
  bst_idcode_t id_value;
  bst_usercode_t uc_value;
  bst_cfg_t cfg_word;

  initial begin
    if (BSR_LEN < 1) begin
      $error("bst_tap boundary chain length must be at least one");
    end
  end

  // idle pins sit high when the host leaves them open
  assign tms_pullup_en = 1'b1;
  assign tdi_pullup_en = 1'b1;

  // link logic resets from the system reset; the instruction register also resets in test-logic-reset
  bst_sync #(
    .WIDTH(1)
  ) u_rst_sync (
    .clk(tck),
    .rst(1'b0),
    .d(sys_rst),
    .q(tck_rst)
  );

  // pins are asynchronous to tck; filtering costs four tck of latency
  bst_sync #(
    .WIDTH(BSR_LEN)
  ) u_pin_sync (
    .clk(tck),
    .rst(tck_rst),
    .d(pin_in),
    .q(pin_sync)
  );

  bst_sync #(
    .WIDTH(BST_UC_USER_LEN)
  ) u_uc_sync (
    .clk(tck),
    .rst(tck_rst),
    .d(user_code),
    .q(user_sync)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BST_RESET: state_next = tms ? BST_RESET : BST_IDLE;
      BST_IDLE: state_next = tms ? BST_SEL_DR : BST_IDLE;
      BST_SEL_DR: state_next = tms ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: state_next = tms ? BST_EXIT1_DR : BST_SHIFT_DR;
      BST_SHIFT_DR: state_next = tms ? BST_EXIT1_DR : BST_SHIFT_DR;
      BST_EXIT1_DR: state_next = tms ? BST_UPD_DR : BST_PAUSE_DR;
      BST_PAUSE_DR: state_next = tms ? BST_EXIT2_DR : BST_PAUSE_DR;
      BST_EXIT2_DR: state_next = tms ? BST_UPD_DR : BST_SHIFT_DR;
      BST_UPD_DR: state_next = tms ? BST_SEL_DR : BST_IDLE;
      BST_SEL_IR: state_next = tms ? BST_RESET : BST_CAP_IR;
      BST_CAP_IR: state_next = tms ? BST_EXIT1_IR : BST_SHIFT_IR;
      BST_SHIFT_IR: state_next = tms ? BST_EXIT1_IR : BST_SHIFT_IR;
      BST_EXIT1_IR: state_next = tms ? BST_UPD_IR : BST_PAUSE_IR;
      BST_PAUSE_IR: state_next = tms ? BST_EXIT2_IR : BST_PAUSE_IR;
      BST_EXIT2_IR: state_next = tms ? BST_UPD_IR : BST_SHIFT_IR;
      BST_UPD_IR: state_next = tms ? BST_SEL_DR : BST_IDLE;
      default: state_next = BST_RESET;
    endcase
  end

  always_ff @(posedge tck) begin
    if (tck_rst) begin
      state_reg <= BST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // instruction register
  always_ff @(posedge tck) begin
    if (tck_rst || state_reg == BST_RESET) begin
      ir_shift_reg <= BST_IR_CAPTURE;
      ir_reg <= BST_IR_RESET;
    end else begin
      case (state_reg)
        BST_CAP_IR: ir_shift_reg <= BST_IR_CAPTURE;
        BST_SHIFT_IR: begin
          // exactly ten shifts leave the new code aligned
          ir_shift_reg <= {tdi, ir_shift_reg[BST_IR_LEN-1:1]};
        end
        BST_UPD_IR: ir_reg <= ir_shift_reg;
        default: ir_shift_reg <= ir_shift_reg;
      endcase
    end
  end

  // unknown codes fall back to bypass
  assign sel_id = ir_reg == BST_OP_IDCODE;
  assign sel_uc = ir_reg == BST_OP_USERCODE;
  assign sel_bsr = ir_reg == BST_OP_SAMPLE || ir_reg == BST_OP_EXTEST;
  assign sel_cfg = ir_reg == BST_OP_CFG_LOAD;
  assign sel_bypass = !(sel_id || sel_uc || sel_bsr || sel_cfg);

  assign id_value.version = BST_ID_VERSION;
  assign id_value.part = BST_ID_PART;
  assign id_value.maker = BST_ID_MAKER;
  assign id_value.lsb = BST_ID_LSB;
  assign uc_value.fixed = BST_UC_FIXED;
  assign uc_value.user = user_sync;

  always_ff @(posedge tck) begin
    if (tck_rst) begin
      bypass_reg <= 1'b0;
    end else if (sel_bypass && state_reg == BST_CAP_DR) begin
      bypass_reg <= 1'b0;
    end else if (sel_bypass && state_reg == BST_SHIFT_DR) begin
      bypass_reg <= tdi;
    end
  end

  always_ff @(posedge tck) begin
    if (tck_rst) begin
      id_shift_reg <= '0;
    end else if (sel_id && state_reg == BST_CAP_DR) begin
      id_shift_reg <= id_value;
    end else if (sel_id && state_reg == BST_SHIFT_DR) begin
      // lsb leaves first
      id_shift_reg <= {tdi, id_shift_reg[BST_ID_LEN-1:1]};
    end
  end

  always_ff @(posedge tck) begin
    if (tck_rst) begin
      uc_shift_reg <= '0;
    end else if (sel_uc && state_reg == BST_CAP_DR) begin
      uc_shift_reg <= uc_value;
    end else if (sel_uc && state_reg == BST_SHIFT_DR) begin
      uc_shift_reg <= {tdi, uc_shift_reg[BST_ID_LEN-1:1]};
    end
  end

  // boundary chain: one cell per pin
  always_ff @(posedge tck) begin
    if (tck_rst) begin
      bsr_shift_reg <= '0;
    end else if (sel_bsr && state_reg == BST_CAP_DR) begin
      bsr_shift_reg <= pin_sync;
    end else if (sel_bsr && state_reg == BST_SHIFT_DR) begin
      if (BSR_LEN == 1) begin
        bsr_shift_reg[0] <= tdi;
      end else begin
        bsr_shift_reg <= {tdi, bsr_shift_reg[BSR_LEN-1:1]};
      end
    end
  end

  // update latch holds the preload across instruction changes
  always_ff @(posedge tck) begin
    if (tck_rst) begin
      bsr_upd_reg <= '0;
    end else if (sel_bsr && state_reg == BST_UPD_DR) begin
      bsr_upd_reg <= bsr_shift_reg;
    end
  end

  // only extest drives the pins from the update latch instead of the core
  assign pin_out = (ir_reg == BST_OP_EXTEST) ? bsr_upd_reg : core_out;

  // configuration stream, lsb first, one byte per eight shifts
  always_ff @(posedge tck) begin
    if (tck_rst) begin
      cfg_shift_reg <= '0;
      cfg_cnt_reg <= '0;
    end else if (sel_cfg && state_reg == BST_CAP_DR) begin
      cfg_cnt_reg <= '0;
    end else if (sel_cfg && state_reg == BST_SHIFT_DR) begin
      cfg_shift_reg <= {tdi, cfg_shift_reg[BST_CFG_W-1:1]};
      cfg_cnt_reg <= cfg_cnt_reg + 3'h1;
    end
  end

  // a partial byte at exit is dropped
  always_ff @(posedge tck) begin
    if (tck_rst) begin
      cfg_stb <= 1'b0;
    end else begin
      cfg_stb <= sel_cfg && state_reg == BST_SHIFT_DR &&
                 cfg_cnt_reg == 3'h7;
    end
  end

  // busy from the load instruction until the done instruction
  always_ff @(posedge tck) begin
    if (tck_rst) begin
      cfg_busy_reg <= 1'b0;
      cfg_done_reg <= 1'b0;
    end else if (state_reg == BST_UPD_IR) begin
      if (ir_shift_reg == BST_OP_CFG_LOAD) begin
        cfg_busy_reg <= 1'b1;
        cfg_done_reg <= 1'b0;
      end else if (ir_shift_reg == BST_OP_CFG_DONE && cfg_busy_reg) begin
        cfg_busy_reg <= 1'b0;
        cfg_done_reg <= 1'b1;
      end
    end
  end

  assign cfg_word.busy = cfg_busy_reg;
  assign cfg_word.data = cfg_shift_reg;

  bst_xfer u_xfer (
    .tck(tck),
    .tck_rst(tck_rst),
    .byte_stb(cfg_stb),
    .cfg_in(cfg_word),
    .clk(clk),
    .sys_rst(sys_rst),
    .cfg_out(cfg_out),
    .cfg_valid(cfg_valid)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_done_s1_reg <= 1'b0;
      cfg_done_s2_reg <= 1'b0;
      cfg_done <= 1'b0;
    end else begin
      cfg_done_s1_reg <= cfg_done_reg;
      cfg_done_s2_reg <= cfg_done_s1_reg;
      cfg_done <= cfg_done_s2_reg;
    end
  end

  always_comb begin
    tdo_next = 1'b0;
    if (state_reg == BST_SHIFT_IR) begin
      tdo_next = ir_shift_reg[0];
    end else if (sel_id) begin
      tdo_next = id_shift_reg[0];
    end else if (sel_uc) begin
      tdo_next = uc_shift_reg[0];
    end else if (sel_bsr) begin
      tdo_next = bsr_shift_reg[0];
    end else if (sel_cfg) begin
      tdo_next = cfg_shift_reg[0];
    end else begin
      tdo_next = bypass_reg;
    end
  end

  // falling edge gives the next device half a period of setup
  always_ff @(negedge tck) begin
    if (tck_rst) begin
      tdo_out <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else begin
      tdo_out <= tdo_next;
      tdo_oe_n <= !(state_reg == BST_SHIFT_IR ||
                    state_reg == BST_SHIFT_DR);
    end
  end

endmodule

// *** tb/bst_tap_props.sv ***
`timescale 1ns/1ps
module bst_tap_props
  import bst_pkg::*;
#(
  parameter int BSR_LEN = BST_BSR_LEN
) (
  // system side
  input wire logic clk,
  input wire logic sys_rst,
  // test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo_out,
  input wire logic tdo_oe_n,
  input wire logic tms_pullup_en,
  input wire logic tdi_pullup_en,
  // pins and configuration
  input wire logic [BSR_LEN-1:0] pin_in,
  input wire logic [BSR_LEN-1:0] core_out,
  input wire logic [BSR_LEN-1:0] pin_out,
  input wire logic [BST_UC_USER_LEN-1:0] user_code,
  input wire bst_cfg_t cfg_out,
  input wire logic cfg_valid,
  input wire logic cfg_done
);
  a_pullups_on: assert property (
    @(posedge clk) disable iff (sys_rst) tms_pullup_en && tdi_pullup_en)
    else $error("pull-up enable low");
  a_valid_one_clk: assert property (
    @(posedge clk) disable iff (sys_rst) cfg_valid |=> !cfg_valid)
    else $error("config valid longer than one clock");
  a_data_held: assert property (
    @(posedge clk) disable iff (sys_rst) $changed(cfg_out.data) |-> cfg_valid)
    else $error("config data moved without valid");
  a_cfg_reset: assert property (
    @(posedge clk) sys_rst |=> !cfg_valid && !cfg_done)
    else $error("config outputs not cleared by reset");
  // tck is low for at least 83 ns after a falling edge, so a change seen on clk
  // while tck is high means tdo moved on the rising edge
  a_oe_on_fall: assert property (
    @(posedge clk) disable iff (sys_rst) $changed(tdo_oe_n) |-> !tck)
    else $error("tdo enable changed off the falling edge");
  a_tdo_on_fall: assert property (
    @(posedge clk) disable iff (sys_rst) $changed(tdo_out) |-> !tck)
    else $error("tdo changed off the falling edge");
  a_drive_in_shift: assert property (
    @(posedge tck) disable iff (sys_rst)
    $fell(tdo_oe_n) |-> !$past(tms) && !$past(tms, 2))
    else $error("tdo driven without entering shift");
  a_release_exit: assert property (
    @(posedge tck) disable iff (sys_rst) $rose(tdo_oe_n) |-> $past(tms))
    else $error("tdo released without leaving shift");
endmodule

bind bst_tap bst_tap_props #(.BSR_LEN(BSR_LEN)) u_props (
  .clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
  .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .tms_pullup_en(tms_pullup_en),
  .tdi_pullup_en(tdi_pullup_en), .pin_in(pin_in), .core_out(core_out),
  .pin_out(pin_out), .user_code(user_code), .cfg_out(cfg_out),
  .cfg_valid(cfg_valid), .cfg_done(cfg_done));

// *** tb/bst_host.sv ***
`timescale 1ns/1ps
module bst_host (
  // test port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one 160 ns period; tck rests low between frames and rises 3 ns
  // after a clk edge, so tdo moves well inside the low phase
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #83;
    q = tdo;
    tck = 1'b1;
    #77;
    tck = 1'b0;
  endtask

  task automatic reset_tap();
    logic q;
    repeat (6) tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
  endtask

  // from idle to idle; n of at most 32 bits, lsb first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
    output logic [31:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b1, q);
    if (ir) begin
      tick(1'b1, 1'b1, q);
    end
    tick(1'b0, 1'b1, q);
    tick(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
  endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import bst_pkg::*;
  localparam int BLEN = 8;
  localparam logic [9:0] OPS [2] = '{BST_OP_BYPASS, 10'h155};
  logic clk;
  logic sys_rst;
  logic tck, tms, tdi, tdo_out, tdo_oe_n, cfg_valid, cfg_done;
  wire tdo_line;
  logic [BLEN-1:0] pin_in, core_out, pin_out, preload;
  logic [BST_UC_USER_LEN-1:0] user_code;
  bst_cfg_t cfg_out;
  bst_cfg_t cfg_q[$];
  int exp_q[$];
  int miscompares, checked, cycles;
  logic [31:0] got, din;

  assign tdo_line = tdo_oe_n ? 1'bz : tdo_out;

  bst_tap #(.BSR_LEN(BLEN)) uut (
    .clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .tms_pullup_en(),
    .tdi_pullup_en(), .pin_in(pin_in), .core_out(core_out),
    .pin_out(pin_out), .user_code(user_code), .cfg_out(cfg_out),
    .cfg_valid(cfg_valid), .cfg_done(cfg_done));

  bst_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    checked++;
    if (got_v !== exp_v) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic chk_pins(input logic [BLEN-1:0] got_v,
    input logic [BLEN-1:0] exp_v);
    checked++;
    if (got_v !== exp_v) begin
      miscompares++;
      $display("[FAIL] %0t pins %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic chk_cfg(input bst_cfg_t got_v, input bst_cfg_t exp_v);
    checked++;
    if (got_v !== exp_v) begin
      miscompares++;
      $display("[FAIL] %0t config word %h expected %h", $time, got_v,
        exp_v);
    end
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cfg_valid === 1'b1) begin
      cfg_q.push_back(cfg_out);
    end
    if (cycles == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    sys_rst = 1'b1;
    pin_in = '0;
    core_out = '0;
    user_code = '0;
    miscompares = 0;
    checked = 0;
    cycles = 0;
    din = $urandom(91604);
    // tck must run during reset so its filtered copy reaches the port
    repeat (10) @(posedge clk);
    host.reset_tap();
    @(posedge clk);
    sys_rst <= 1'b0;
    user_code <= BST_UC_USER_LEN'($urandom);
    core_out <= BLEN'($urandom);
    pin_in <= BLEN'($urandom);
    host.reset_tap();
    host.scan(1'b0, 32, '1, got);
    chk(got,
      {BST_ID_VERSION, BST_ID_PART, BST_ID_MAKER, 1'b1});
    chk_pins(pin_out, core_out);
    host.scan(1'b1, 10, {22'h0, BST_OP_USERCODE}, got);
    chk(got, {22'h0, BST_IR_CAPTURE});
    host.scan(1'b0, 32, '1, got);
    chk(got, {BST_UC_FIXED, user_code});
    foreach (OPS[i]) begin
      din = $urandom;
      host.scan(1'b1, 10, {22'h0, OPS[i]}, got);
      host.scan(1'b0, 32, din, got);
      chk(got, {din[30:0], 1'b0});
    end
    host.scan(1'b1, 10, {22'h0, BST_OP_SAMPLE}, got);
    din = $urandom;
    host.scan(1'b0, 16, din, got);
    chk(got, {16'h0, din[7:0], pin_in});
    chk_pins(pin_out, core_out);
    preload = din[15:8];
    @(posedge clk);
    pin_in <= BLEN'($urandom);
    host.scan(1'b1, 10, {22'h0, BST_OP_EXTEST}, got);
    chk_pins(pin_out, preload);
    din = $urandom;
    host.scan(1'b0, BLEN, din, got);
    chk(got, {24'h0, pin_in});
    chk_pins(pin_out, din[7:0]);
    // boundary tests are done; configuration follows, never interleaved
    host.scan(1'b1, 10, {22'h0, BST_OP_CFG_LOAD}, got);
    din = $urandom;
    host.scan(1'b0, 20, din, got);
    for (int i = 0; i < 20 / 8; i++) begin
      exp_q.push_back(int'(din[8*i+:8]));
    end
    host.scan(1'b1, 10, {22'h0, BST_OP_CFG_DONE}, got);
    repeat (8) @(posedge clk);
    chk(cfg_q.size(), exp_q.size());
    foreach (exp_q[i]) begin
      chk_cfg(cfg_q[i], {1'b1, 8'(exp_q[i])});
    end
    chk({31'h0, cfg_done}, 32'h1);
    host.scan(1'b1, 10, {22'h0, BST_OP_IDCODE}, got);
    host.scan(1'b0, 32, '1, got);
    chk(got[0], 1'b1);
    tally_and_finish();
  end
endmodule
